// [rtl/add_and_shift_execute_unit.sv]
// execute unit: add, and, shift datapath with apb register access
// Functional notes
// - pointer add: sign-extended 6-bit literal, flags kept
// - pointer sum wraps modulo 65536
// - and literal into working register, zero only
// - add literal into working register, c dc z
// - and working register with file, zero only
// - dest 0 to working register, 1 to file
// - add working register and file, c dc z
// - add with carry, c dc z updated
// - arithmetic shift right, bit0 to carry
// - one instruction cycle without penalty
// - extra cycle when indirect pointer msb set
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module add_and_shift_execute_unit #(
  parameter int FILE_DEPTH = 128 // file registers, 7-bit address
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output logic op_done
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (FILE_DEPTH != 128)
  begin : g_depth_check
    $error("FILE_DEPTH must be 128 to match the 7-bit file address");
  end

  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  // returns {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  // maps an indirect file address onto the pointer's low bits
  function automatic logic [6:0] eff_addr(input logic [6:0] a, input logic [15:0] p0,
                                          input logic [15:0] p1);
    if (a == exec_unit_pkg::FILE_INDIRECT0)
      return p0[6:0];
    else if (a == exec_unit_pkg::FILE_INDIRECT1)
      return p1[6:0];
    else
      return a;
  endfunction

  // true for the operations that read a file register
  function automatic logic is_file_op(input logic [3:0] op);
    return (op == exec_unit_pkg::OP_AND_FILE) || (op == exec_unit_pkg::OP_ADD_FILE) ||
           (op == exec_unit_pkg::OP_ADDC_FILE) || (op == exec_unit_pkg::OP_ASR_FILE);
  endfunction

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_STALL, S_EXEC} state_t;

  state_t state_reg, state_next;       // sequencer
  exec_unit_pkg::cmd_t cmd_reg, cmd_next; // operation in flight
  logic [7:0] acc_reg, acc_next;       // working register
  exec_unit_pkg::flags_t flags_reg, flags_next; // c, dc, z
  logic [15:0] ptr0_reg, ptr0_next;    // indirect pointer pair 0
  logic [15:0] ptr1_reg, ptr1_next;    // indirect pointer pair 1
  logic done_reg, done_next;           // completion pulse
  logic [31:0] rdata_reg, rdata_next;  // read data, loaded in setup cycle
  logic [7:0] file_mem [FILE_DEPTH];   // data memory file, no reset

  // bus decode
  logic setup_ph;                      // first apb cycle
  logic access_ph;                     // access cycle, pready always high
  logic wr_acc;                        // write completing this edge
  logic hit_cmd, hit_acc, hit_st, hit_p0, hit_p1, hit_file, hit_any;

  // execution datapath
  logic [6:0] f_addr;                  // resolved file address
  logic [7:0] f_val;                   // file operand
  logic [7:0] res;                     // 8-bit result
  logic [9:0] sum;                     // adder output
  logic [15:0] ptr_sum;                // pointer add result
  logic file_op;                       // operation reads the file
  logic penalty;                       // indirect pointer msb set
  logic mem_we;                        // file write strobe
  logic [6:0] mem_wa;                  // file write address
  logic [7:0] mem_wd;                  // file write data
  exec_unit_pkg::cmd_t new_cmd;        // command from write data

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states: the answer comes in the access cycle
  always_comb
  begin
    setup_ph = psel && !penable;
    access_ph = psel && penable;
    hit_cmd = (paddr == exec_unit_pkg::OFS_CMD);
    hit_acc = (paddr == exec_unit_pkg::OFS_ACC);
    hit_st = (paddr == exec_unit_pkg::OFS_STATUS);
    hit_p0 = (paddr == exec_unit_pkg::OFS_PTR0);
    hit_p1 = (paddr == exec_unit_pkg::OFS_PTR1);
    hit_file = (paddr[11:9] == exec_unit_pkg::FILE_WIN_TAG) && (paddr[1:0] == 2'b00);
    hit_any = hit_cmd || hit_acc || hit_st || hit_p0 || hit_p1 || hit_file;
    wr_acc = access_ph && pwrite && hit_any;
    new_cmd = exec_unit_pkg::cmd_t'(pwdata[exec_unit_pkg::CMD_WIDTH-1:0]);
  end

  assign pready = access_ph;
  assign pslverr = access_ph && !hit_any;
  assign prdata = rdata_reg;
  assign busy = (state_reg != S_IDLE);
  assign op_done = done_reg;

  // ----------------------------------------------------------------
  // read data next value
  // ----------------------------------------------------------------
  // sampled in setup so prdata comes from a flop during access
  always_comb
  begin
    rdata_next = rdata_reg;
    if (setup_ph)
    begin
      rdata_next = 32'h0000_0000;
      if (hit_acc)
        rdata_next[7:0] = acc_reg;
      else if (hit_st)
      begin
        rdata_next[exec_unit_pkg::ST_C_BIT] = flags_reg.c;
        rdata_next[exec_unit_pkg::ST_DC_BIT] = flags_reg.dc;
        rdata_next[exec_unit_pkg::ST_Z_BIT] = flags_reg.z;
        rdata_next[exec_unit_pkg::ST_BUSY_BIT] = busy;
      end
      else if (hit_p0)
        rdata_next[15:0] = ptr0_reg;
      else if (hit_p1)
        rdata_next[15:0] = ptr1_reg;
      else if (hit_file)
        rdata_next[7:0] = file_mem[paddr[8:2]];
    end
  end

  // ----------------------------------------------------------------
  // operand fetch and arithmetic
  // ----------------------------------------------------------------
  always_comb
  begin
    f_addr = eff_addr(cmd_reg.lit[6:0], ptr0_reg, ptr1_reg);
    f_val = file_mem[f_addr];
    file_op = is_file_op(cmd_reg.op);
    // sign-extended literal, 16-bit sum wraps on its own
    ptr_sum = (cmd_reg.ptr_sel ? ptr1_reg : ptr0_reg) +
              {{10{cmd_reg.lit[5]}}, cmd_reg.lit[5:0]};
    sum = 10'h000;
    res = acc_reg;
    case (cmd_reg.op)
      exec_unit_pkg::OP_AND_LIT: res = acc_reg & cmd_reg.lit;
      exec_unit_pkg::OP_ADD_LIT:
      begin
        sum = add8(acc_reg, cmd_reg.lit, 1'b0);
        res = sum[7:0];
      end
      exec_unit_pkg::OP_AND_FILE: res = acc_reg & f_val;
      exec_unit_pkg::OP_ADD_FILE:
      begin
        sum = add8(acc_reg, f_val, 1'b0);
        res = sum[7:0];
      end
      exec_unit_pkg::OP_ADDC_FILE:
      begin
        sum = add8(acc_reg, f_val, flags_reg.c);
        res = sum[7:0];
      end
      exec_unit_pkg::OP_ASR_FILE: res = {f_val[7], f_val[7:1]};
      default: res = acc_reg;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer and architectural state, next values
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    ptr0_next = ptr0_reg;
    ptr1_next = ptr1_reg;
    done_next = 1'b0;
    penalty = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        // software writes only while idle, so no write races an operation
        if (wr_acc && hit_cmd)
        begin
          cmd_next = new_cmd;
          // high pointer behind an indirect address costs one more cycle
          if (is_file_op(new_cmd.op))
          begin
            if (new_cmd.lit[6:0] == exec_unit_pkg::FILE_INDIRECT0)
              penalty = ptr0_reg[15];
            else if (new_cmd.lit[6:0] == exec_unit_pkg::FILE_INDIRECT1)
              penalty = ptr1_reg[15];
          end
          state_next = penalty ? S_STALL : S_EXEC;
        end
        else if (wr_acc && hit_acc)
          acc_next = pwdata[7:0];
        else if (wr_acc && hit_st)
        begin
          flags_next.c = pwdata[exec_unit_pkg::ST_C_BIT];
          flags_next.dc = pwdata[exec_unit_pkg::ST_DC_BIT];
          flags_next.z = pwdata[exec_unit_pkg::ST_Z_BIT];
        end
        else if (wr_acc && hit_p0)
          ptr0_next = pwdata[15:0];
        else if (wr_acc && hit_p1)
          ptr1_next = pwdata[15:0];
      end
      S_STALL: state_next = S_EXEC; // the extra instruction cycle
      S_EXEC:
      begin
        state_next = S_IDLE;
        done_next = 1'b1;
        if (cmd_reg.op == exec_unit_pkg::OP_POINTER_ADD)
        begin
          if (cmd_reg.ptr_sel)
            ptr1_next = ptr_sum;
          else
            ptr0_next = ptr_sum;
        end
        else if (cmd_reg.op <= exec_unit_pkg::OP_ASR_FILE)
        begin
          // literal ops always land in the working register
          if (!file_op || !cmd_reg.dest)
            acc_next = res;
          flags_next.z = (res == 8'h00);
          if (cmd_reg.op == exec_unit_pkg::OP_ASR_FILE)
            flags_next.c = f_val[0];
          else if (cmd_reg.op == exec_unit_pkg::OP_ADD_LIT ||
                   cmd_reg.op == exec_unit_pkg::OP_ADD_FILE ||
                   cmd_reg.op == exec_unit_pkg::OP_ADDC_FILE)
          begin
            // and operations leave carry and digit carry alone
            flags_next.c = sum[9];
            flags_next.dc = sum[8];
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // file write next values
  // ----------------------------------------------------------------
  // bus writes only while idle, result writes only in exec: never both
  always_comb
  begin
    mem_we = 1'b0;
    mem_wa = paddr[8:2];
    mem_wd = pwdata[7:0];
    if (state_reg == S_IDLE && wr_acc && hit_file)
      mem_we = 1'b1;
    else if (state_reg == S_EXEC && file_op && cmd_reg.dest)
    begin
      mem_we = 1'b1;
      mem_wa = f_addr;
      mem_wd = res;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= S_IDLE;
      cmd_reg <= '0;
      acc_reg <= exec_unit_pkg::ACC_RST;
      flags_reg <= exec_unit_pkg::FLAGS_RST;
      ptr0_reg <= exec_unit_pkg::PTR_RST;
      ptr1_reg <= exec_unit_pkg::PTR_RST;
      done_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  // memory has no reset; software loads it before use
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      file_mem[mem_wa] <= mem_wd;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  logic exec_now;
  assign exec_now = (state_reg == S_EXEC);

  sequence seq_issue_fast;
    (state_reg == S_IDLE) && wr_acc && hit_cmd && !penalty;
  endsequence
  sequence seq_issue_slow;
    (state_reg == S_IDLE) && wr_acc && hit_cmd && penalty;
  endsequence

  AST_PTR_ADD: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_POINTER_ADD && !cmd_reg.ptr_sel
    |=> ptr0_reg == $past(ptr0_reg) + {{10{$past(cmd_reg.lit[5])}}, $past(cmd_reg.lit[5:0])}
    && $stable(flags_reg))
    else $error("pointer add result or flags wrong");
  AST_PTR_WRAP: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_POINTER_ADD
    && cmd_reg.ptr_sel && ptr1_reg == 16'h0010 && cmd_reg.lit[5:0] == 6'h20
    |=> ptr1_reg == 16'hFFF0)
    else $error("pointer did not wrap below zero");
  AST_AND_LIT: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_AND_LIT
    |=> acc_reg == ($past(acc_reg) & $past(cmd_reg.lit)) && $stable(flags_reg.c))
    else $error("literal and wrong");
  AST_ADD_LIT: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_ADD_LIT
    |=> {flags_reg.c, acc_reg} == {1'b0, $past(acc_reg)} + {1'b0, $past(cmd_reg.lit)})
    else $error("literal add wrong");
  AST_AND_FILE: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_AND_FILE && !cmd_reg.dest
    |=> acc_reg == ($past(acc_reg) & $past(f_val)) && $stable(flags_reg.dc))
    else $error("file and wrong");
  AST_DEST_FILE: assert property (
    exec_now && file_op && cmd_reg.dest |=> $stable(acc_reg))
    else $error("working register changed for file destination");
  AST_ADD_FILE: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_ADD_FILE && !cmd_reg.dest
    |=> {flags_reg.c, acc_reg} == {1'b0, $past(acc_reg)} + {1'b0, $past(f_val)})
    else $error("file add wrong");
  AST_ADDC: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_ADDC_FILE && !cmd_reg.dest
    |=> {flags_reg.c, acc_reg} ==
    {1'b0, $past(acc_reg)} + {1'b0, $past(f_val)} + {8'h00, $past(flags_reg.c)})
    else $error("add with carry wrong");
  AST_ASR: assert property (
    exec_now && cmd_reg.op == exec_unit_pkg::OP_ASR_FILE && !cmd_reg.dest
    |=> acc_reg == {$past(f_val[7]), $past(f_val[7:1])}
    && flags_reg.c == $past(f_val[0]) && $stable(flags_reg.dc))
    else $error("shift wrong");
  AST_ONE_CYCLE: assert property (seq_issue_fast |=> exec_now ##1 op_done && !busy)
    else $error("operation not done in one cycle");
  AST_PENALTY: assert property (
    seq_issue_slow |=> state_reg == S_STALL ##1 exec_now ##1 op_done)
    else $error("penalty cycle missing");
  AST_ZERO: assert property (
    exec_now && cmd_reg.op != exec_unit_pkg::OP_POINTER_ADD
    && cmd_reg.op <= exec_unit_pkg::OP_ASR_FILE |=> flags_reg.z == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  AST_FLAGS_HOLD: assert property (
    state_reg == S_STALL || (state_reg == S_IDLE && !(wr_acc && hit_st))
    |=> $stable(flags_reg))
    else $error("flags moved outside completion");

endmodule

`default_nettype wire

// [rtl/exec_unit_pkg.sv]
// package: register map, command layout and constants of the execute unit
package exec_unit_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CMD = 12'h000;      // command launch, write only
  localparam logic [11:0] OFS_ACC = 12'h004;      // working register
  localparam logic [11:0] OFS_STATUS = 12'h008;   // flags and busy
  localparam logic [11:0] OFS_PTR0 = 12'h00C;     // indirect pointer pair 0
  localparam logic [11:0] OFS_PTR1 = 12'h010;     // indirect pointer pair 1
  localparam logic [2:0] FILE_WIN_TAG = 3'h1;     // paddr[11:9]: file window 0x200..0x3FC

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_C_BIT = 0;                    // carry flag
  localparam int ST_DC_BIT = 1;                   // digit_carry_flag
  localparam int ST_Z_BIT = 2;                    // zero flag
  localparam int ST_BUSY_BIT = 8;                 // operation in flight, read only
  localparam int CMD_WIDTH = 14;                  // command word lives in pwdata[13:0]

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_POINTER_ADD = 4'h0;   // pointer_add_literal
  localparam logic [3:0] OP_AND_LIT = 4'h1;       // and_literal_into_acc
  localparam logic [3:0] OP_ADD_LIT = 4'h2;       // add_literal_into_acc
  localparam logic [3:0] OP_AND_FILE = 4'h3;      // and_acc_with_file
  localparam logic [3:0] OP_ADD_FILE = 4'h4;      // add_acc_with_file
  localparam logic [3:0] OP_ADDC_FILE = 4'h5;     // add_acc_file_with_carry
  localparam logic [3:0] OP_ASR_FILE = 4'h6;      // arith_shift_right_file

  // ----------------------------------------------------------------
  // file addresses, reset values, timing
  // ----------------------------------------------------------------
  localparam logic [6:0] FILE_INDIRECT0 = 7'h00;  // indirect_data_register via pointer 0
  localparam logic [6:0] FILE_INDIRECT1 = 7'h01;  // indirect_data_register via pointer 1
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam int INSTR_CYCLES = 1;                // one instruction cycle = one clock
  localparam int PENALTY_CYCLES = 1;              // extra cycle for high indirect pointer

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic ptr_sel;     // which pointer pair
    logic dest;        // 0: working register, 1: file register
    logic [3:0] op;    // operation code
    logic [7:0] lit;   // literal, file address in [6:0], 6-bit k in [5:0]
  } cmd_t;

  typedef struct packed
  {
    logic z;
    logic dc;
    logic c;
  } flags_t;

  localparam flags_t FLAGS_RST = '{z: 1'b0, dc: 1'b0, c: 1'b0};

endpackage

// [verif/add_and_shift_execute_unit_bench.sv]
// testbench: register-level checks of the execute unit datapath
`timescale 1ns/1ps
`default_nettype none

module add_and_shift_execute_unit_bench;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, busy, op_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_mismatch = 0;
  int tests_run = 0;
  // operand vectors: carries, zero results, sign bit set
  logic [7:0] va[4] = '{8'h88, 8'h0F, 8'hC4, 8'h81};
  logic [7:0] vf[4] = '{8'h88, 8'hF0, 8'h3C, 8'hFF};
  logic [2:0] vs[4] = '{3'b001, 3'b110, 3'b000, 3'b101};

  add_and_shift_execute_unit DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .op_done(op_done));
  apb_host_model host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] fa(input logic [6:0] a);
    return {exec_unit_pkg::FILE_WIN_TAG, a, 2'b00};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0000_0000);
  endtask

  // launch a command and count clocks until completion shows
  task automatic cmd(input logic [13:0] w, input int pen);
    int n;
    n = 0;
    wr(exec_unit_pkg::OFS_CMD, {18'h0, w});
    #1;
    chk({31'h0, busy}, 32'h0000_0001);
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (op_done !== 1'b1 && n < 20);
    chk(n, exec_unit_pkg::INSTR_CYCLES + pen * exec_unit_pkg::PENALTY_CYCLES);
  endtask

  // reference datapath: result in [10:3], flags {z,dc,c} in [2:0]
  function automatic logic [10:0] alu(input logic [3:0] op, input logic [7:0] a,
                                      input logic [7:0] f, input logic [2:0] fl);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [2:0] o;
    o = fl;
    h = a[3:0] + f[3:0];
    s = a + f;
    if (op == 4'h5)
    begin
      h = h + fl[0];
      s = s + fl[0];
    end
    case (op)
      4'h1, 4'h3: r = a & f;
      4'h6: r = {f[7], f[7:1]};
      default: r = s[7:0];
    endcase
    o[2] = (r == 8'h00);
    if (op == 4'h2 || op == 4'h4 || op == 4'h5)
      o[1:0] = {h[4], s[8]};
    if (op == 4'h6)
      o[0] = f[0];
    return {r, o};
  endfunction

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial
  begin
    #40000;
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [10:0] e;
    logic [31:0] r;
    logic er;
    resetn = 1'b0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    rchk(exec_unit_pkg::OFS_ACC, 32'h0000_0000);
    rchk(exec_unit_pkg::OFS_STATUS, 32'h0000_0000);
    rchk(exec_unit_pkg::OFS_PTR0, 32'h0000_0000);
    // pointer add wraps both ways, flags left alone
    wr(exec_unit_pkg::OFS_PTR0, 32'h0000_FFF0);
    wr(exec_unit_pkg::OFS_PTR1, 32'h0000_0010);
    wr(exec_unit_pkg::OFS_STATUS, 32'h0000_0007);
    cmd({2'b00, exec_unit_pkg::OP_POINTER_ADD, 8'h1F}, 0);
    cmd({2'b10, exec_unit_pkg::OP_POINTER_ADD, 8'h20}, 0);
    rchk(exec_unit_pkg::OFS_PTR0, 32'h0000_000F);
    rchk(exec_unit_pkg::OFS_PTR1, 32'h0000_FFF0);
    rchk(exec_unit_pkg::OFS_STATUS, 32'h0000_0007);
    // every op except pointer add, and both destinations, over the operand table
    for (int v = 0; v < 4; v++)
      for (int op = 1; op < 7; op++)
        for (int d = 0; d < 2; d++)
        begin
          wr(exec_unit_pkg::OFS_ACC, {24'h0, va[v]});
          wr(fa(7'h09), {24'h0, vf[v]});
          wr(exec_unit_pkg::OFS_STATUS, {29'h0, vs[v]});
          e = alu(op[3:0], va[v], vf[v], vs[v]);
          cmd({1'b0, d[0], op[3:0], (op < 3) ? vf[v] : 8'h09}, 0);
          rchk(exec_unit_pkg::OFS_ACC, {24'h0, (d == 1 && op > 2) ? va[v] : e[10:3]});
          rchk(fa(7'h09), {24'h0, (d == 1 && op > 2) ? e[10:3] : vf[v]});
          rchk(exec_unit_pkg::OFS_STATUS, {29'h0, e[2:0]});
        end
    // indirect operand, with and without the pointer msb penalty
    wr(exec_unit_pkg::OFS_PTR0, 32'h0000_8005);
    wr(exec_unit_pkg::OFS_PTR1, 32'h0000_0005);
    wr(fa(7'h05), 32'h0000_0011);
    wr(exec_unit_pkg::OFS_ACC, 32'h0000_0022);
    cmd({2'b00, exec_unit_pkg::OP_ADD_FILE, 8'h00}, 1);
    rchk(exec_unit_pkg::OFS_ACC, 32'h0000_0033);
    cmd({2'b10, exec_unit_pkg::OP_ADD_FILE, 8'h01}, 0);
    rchk(exec_unit_pkg::OFS_ACC, 32'h0000_0044);
    // the penalty cycle keeps busy up for a read that follows at once
    wr(exec_unit_pkg::OFS_CMD, {18'h0, 2'b00, exec_unit_pkg::OP_ADD_FILE, 8'h00});
    rchk(exec_unit_pkg::OFS_STATUS, 32'h0000_0100);
    rchk(exec_unit_pkg::OFS_ACC, 32'h0000_0055);
    // undefined codes change nothing and still take one cycle
    wr(exec_unit_pkg::OFS_STATUS, 32'h0000_0007);
    cmd({2'b11, 4'hF, 8'hFF}, 0);
    rchk(exec_unit_pkg::OFS_ACC, 32'h0000_0055);
    rchk(exec_unit_pkg::OFS_STATUS, 32'h0000_0007);
    // unmapped place is refused
    host.xfer(1'b0, 12'h100, 32'h0000_0000, r, er);
    chk({31'h0, er}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    results();
  end
endmodule
`default_nettype wire

// [verif/apb_host_model.sv]
// partner: apb master standing in for the core decoder side
`timescale 1ns/1ps
`default_nettype none

module apb_host_model (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // one transfer: setup, access, hold until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // bounded by the bench watchdog
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show junk so a stale value is never trusted
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire
